// *** src/twbpf_pkg.sv ***
/*
  Constants, command codes and state type for the two-wire bus master.
  Assumes a 50 MHz system clock and a 100 kHz bus clock.
*/
package twbpf_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
  localparam logic [7:0] QTR_LOAD = 8'(QUARTER_CYC - 1);
  localparam logic [7:0] HALF_LOAD = 8'(2 * QUARTER_CYC - 1);
  localparam logic [7:0] CNT_ZERO = 8'h00;
  localparam logic [7:0] CNT_STEP = 8'h01;

  // ----------------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------------
  localparam logic [1:0] CMD_START = 2'h0;
  localparam logic [1:0] CMD_WRITE = 2'h1;
  localparam logic [1:0] CMD_READ = 2'h2;
  localparam logic [1:0] CMD_STOP = 2'h3;

  // ----------------------------------------------------------------------
  // Packet layout
  // ----------------------------------------------------------------------
  localparam logic [6:0] ADDR_GENERAL = 7'h00;
  localparam logic [6:0] ADDR_RESV_MASK = 7'h78;
  localparam logic RW_READ = 1'h1;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_STEP = 4'h1;
  localparam logic [7:0] READ_FILL = 8'hFF;
  localparam logic [8:0] TX_IDLE = 9'h1FF;

  typedef enum logic [3:0] {
    S_IDLE,
    S_WAIT_FREE,
    S_RS_SDA,
    S_ST_SCL,
    S_ST_SDA,
    S_ST_END,
    S_BIT_LOW,
    S_BIT_RISE,
    S_BIT_HIGH,
    S_HOLD,
    S_SP_LOW,
    S_SP_SCL,
    S_SP_SDA
  } twbpf_state_t;

endpackage : twbpf_pkg

// *** src/twbpf_host.sv ***
/*
  Two-wire bus master: START, repeated START, STOP, address and data
  packets, acknowledge handling, clock stretching and busy detection.
  Assumes open-drain pads with pull-ups outside; pin inputs are async.
*/
`timescale 1ns/100ps

// Contract
// - SDA changes only while SCL is low, except START and STOP.
// - START is SDA falling with SCL high; STOP is SDA rising.
// - Bus is busy from START to STOP; never start while busy.
// - Repeated START keeps the bus and behaves like START.
// - Address packet: seven address bits, direction bit, acknowledge bit.
// - Direction bit one means read, zero means write.
// - Addressed slave pulls SDA low in ninth cycle; else leaves high.
// - After an unacknowledged address, only STOP or repeated START.
// - Address byte goes out most significant bit first.
// - Address zero with write is a general call to enabled slaves.
// - General-call address with read is never sent.
// - Addresses with upper four bits all ones are reserved.
// - Data packet: eight bits then acknowledge; low ACK, high NACK.
// - Master makes all clock pulses, START and STOP; receiver acks.
// - Receiver answers its final byte with NACK.
// - Data bytes go out most significant bit first.
// - Transfer is START, address, data, STOP; never START then STOP.
// - Slave may hold SCL low; master waits for real release.
// - Lines are wired-AND; a one is sent by releasing the line.
module twbpf_host
  import twbpf_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_code,
  input wire logic [6:0] cmd_addr,
  input wire logic cmd_rw,
  input wire logic [7:0] cmd_data,
  input wire logic cmd_last,
  output logic cmd_ready,
  output logic done,
  output logic ack,
  output logic [7:0] rx_data,
  output logic error,
  output logic bus_busy
);

  // ----------------------------------------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------------------------------------
  logic rst_m_q;
  logic rst_n_q;
  logic scl_m_q;
  logic scl_s_q;
  logic sda_m_q;
  logic sda_s_q;
  logic sda_d_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_m_q <= 1'h0;
      rst_n_q <= 1'h0;
    end else begin
      rst_m_q <= 1'h1;
      rst_n_q <= rst_m_q;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      scl_m_q <= 1'h1;
      scl_s_q <= 1'h1;
      sda_m_q <= 1'h1;
      sda_s_q <= 1'h1;
      sda_d_q <= 1'h1;
    end else begin
      scl_m_q <= scl_i;
      scl_s_q <= scl_m_q;
      sda_m_q <= sda_i;
      sda_s_q <= sda_m_q;
      sda_d_q <= sda_s_q;
    end
  end

  // ----------------------------------------------------------------------
  // Bus busy detection
  // ----------------------------------------------------------------------
  logic busy_q;
  logic start_seen;
  logic stop_seen;

  assign start_seen = scl_s_q && sda_d_q && !sda_s_q;
  assign stop_seen = scl_s_q && !sda_d_q && sda_s_q;

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      busy_q <= 1'h0;
    end else if (start_seen) begin
      busy_q <= 1'h1;
    end else if (stop_seen) begin
      busy_q <= 1'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  twbpf_state_t state_q;
  logic [7:0] cnt_q;
  logic [3:0] bit_q;
  logic [8:0] tx_q;
  logic [8:0] rx_q;
  logic scl_oe_n_q;
  logic sda_oe_n_q;
  logic scl_o_q;
  logic sda_o_q;
  logic cmd_ready_q;
  logic done_q;
  logic err_q;
  logic ack_q;
  logic [7:0] rx_data_q;
  logic nack_q;
  logic addr_ph_q;
  logic accept;
  logic bad_addr;

  assign accept = cmd_valid && cmd_ready_q;
  assign bad_addr = (cmd_addr == ADDR_GENERAL && cmd_rw == RW_READ) ||
                    ((cmd_addr & ADDR_RESV_MASK) == ADDR_RESV_MASK);

  // Output drivers never go high: a one is a released line
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      scl_o_q <= 1'h0;
      sda_o_q <= 1'h0;
    end else begin
      scl_o_q <= 1'h0;
      sda_o_q <= 1'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state_q <= S_IDLE;
      cnt_q <= CNT_ZERO;
      bit_q <= BIT_FIRST;
      tx_q <= TX_IDLE;
      rx_q <= 9'h000;
      scl_oe_n_q <= 1'h1;
      sda_oe_n_q <= 1'h1;
      cmd_ready_q <= 1'h1;
      done_q <= 1'h0;
      err_q <= 1'h0;
      ack_q <= 1'h0;
      rx_data_q <= 8'h00;
      nack_q <= 1'h0;
      addr_ph_q <= 1'h0;
    end else begin
      done_q <= 1'h0;
      err_q <= 1'h0;
      if (cnt_q != CNT_ZERO) begin
        cnt_q <= cnt_q - CNT_STEP;
      end
      case (state_q)
        S_IDLE, S_HOLD: begin
          if (accept) begin
            if (cmd_code == CMD_START) begin
              if (bad_addr) begin
                err_q <= 1'h1;
              end else begin
                cmd_ready_q <= 1'h0;
                tx_q <= {cmd_addr, cmd_rw, 1'h1};
                nack_q <= 1'h0;
                addr_ph_q <= 1'h1;
                cnt_q <= QTR_LOAD;
                if (state_q == S_IDLE) begin
                  state_q <= S_WAIT_FREE;
                end else begin
                  state_q <= S_RS_SDA;
                end
              end
            end else if (state_q == S_IDLE) begin
              err_q <= 1'h1;
            end else if (cmd_code == CMD_STOP) begin
              cmd_ready_q <= 1'h0;
              sda_oe_n_q <= 1'h0;
              cnt_q <= QTR_LOAD;
              state_q <= S_SP_LOW;
            end else if (nack_q) begin
              err_q <= 1'h1;
            end else begin
              cmd_ready_q <= 1'h0;
              if (cmd_code == CMD_READ) begin
                tx_q <= {READ_FILL, cmd_last};
              end else begin
                tx_q <= {cmd_data, 1'h1};
              end
              bit_q <= BIT_FIRST;
              cnt_q <= HALF_LOAD;
              state_q <= S_BIT_LOW;
            end
          end
        end
        S_WAIT_FREE: begin
          cnt_q <= QTR_LOAD;
          if (!busy_q) begin
            state_q <= S_RS_SDA;
          end
        end
        S_RS_SDA: begin
          sda_oe_n_q <= 1'h1;
          if (cnt_q == CNT_ZERO) begin
            scl_oe_n_q <= 1'h1;
            cnt_q <= QTR_LOAD;
            state_q <= S_ST_SCL;
          end
        end
        S_ST_SCL: begin
          if (!scl_s_q) begin
            cnt_q <= QTR_LOAD;
          end else if (cnt_q == CNT_ZERO) begin
            sda_oe_n_q <= 1'h0;
            cnt_q <= QTR_LOAD;
            state_q <= S_ST_SDA;
          end
        end
        S_ST_SDA: begin
          if (cnt_q == CNT_ZERO) begin
            scl_oe_n_q <= 1'h0;
            cnt_q <= QTR_LOAD;
            state_q <= S_ST_END;
          end
        end
        S_ST_END: begin
          if (cnt_q == CNT_ZERO) begin
            bit_q <= BIT_FIRST;
            cnt_q <= HALF_LOAD;
            state_q <= S_BIT_LOW;
          end
        end
        S_BIT_LOW: begin
          if (cnt_q == QTR_LOAD) begin
            sda_oe_n_q <= tx_q[8];
          end
          if (cnt_q == CNT_ZERO) begin
            scl_oe_n_q <= 1'h1;
            cnt_q <= HALF_LOAD;
            state_q <= S_BIT_RISE;
          end
        end
        S_BIT_RISE: begin
          cnt_q <= HALF_LOAD;
          if (scl_s_q) begin
            state_q <= S_BIT_HIGH;
          end
        end
        S_BIT_HIGH: begin
          if (cnt_q == CNT_ZERO) begin
            rx_q <= {rx_q[7:0], sda_s_q};
            tx_q <= {tx_q[7:0], 1'h1};
            scl_oe_n_q <= 1'h0;
            if (bit_q == BIT_LAST) begin
              rx_data_q <= rx_q[7:0];
              ack_q <= !sda_s_q;
              nack_q <= addr_ph_q && sda_s_q;
              addr_ph_q <= 1'h0;
              done_q <= 1'h1;
              cmd_ready_q <= 1'h1;
              state_q <= S_HOLD;
            end else begin
              bit_q <= bit_q + BIT_STEP;
              cnt_q <= HALF_LOAD;
              state_q <= S_BIT_LOW;
            end
          end
        end
        S_SP_LOW: begin
          if (cnt_q == CNT_ZERO) begin
            scl_oe_n_q <= 1'h1;
            cnt_q <= QTR_LOAD;
            state_q <= S_SP_SCL;
          end
        end
        S_SP_SCL: begin
          if (!scl_s_q) begin
            cnt_q <= QTR_LOAD;
          end else if (cnt_q == CNT_ZERO) begin
            sda_oe_n_q <= 1'h1;
            cnt_q <= QTR_LOAD;
            state_q <= S_SP_SDA;
          end
        end
        S_SP_SDA: begin
          if (cnt_q == CNT_ZERO) begin
            done_q <= 1'h1;
            cmd_ready_q <= 1'h1;
            nack_q <= 1'h0;
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  assign scl_o = scl_o_q;
  assign scl_oe_n = scl_oe_n_q;
  assign sda_o = sda_o_q;
  assign sda_oe_n = sda_oe_n_q;
  assign cmd_ready = cmd_ready_q;
  assign done = done_q;
  assign ack = ack_q;
  assign rx_data = rx_data_q;
  assign error = err_q;
  assign bus_busy = busy_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  a_sda_stable_high: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    (state_q == S_BIT_HIGH && $past(state_q) == S_BIT_HIGH)
      |-> $stable(sda_oe_n_q))
    else $error("SDA moved while SCL was high in a bit");

  a_start_shape: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    $rose(state_q == S_ST_SDA) |-> (!sda_oe_n_q && scl_oe_n_q))
    else $error("START not formed with SCL released");

  a_no_start_busy: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    (state_q == S_WAIT_FREE && busy_q) |=> state_q == S_WAIT_FREE)
    else $error("START begun while bus busy");

  a_rep_start_path: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    (state_q == S_HOLD && accept && cmd_code == CMD_START && !bad_addr)
      |=> (state_q == S_RS_SDA) ##[1:200] (state_q == S_ST_SCL))
    else $error("Repeated START did not release SDA first");

  a_addr_load: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    (accept && cmd_code == CMD_START && !bad_addr)
      |=> (tx_q == {$past(cmd_addr), $past(cmd_rw), 1'h1}))
    else $error("Address packet not loaded as address, direction, ack");

  a_nine_bits: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    (state_q == S_BIT_HIGH && cnt_q == CNT_ZERO && bit_q == BIT_LAST)
      |=> (state_q == S_HOLD && done_q && cmd_ready_q))
    else $error("Packet did not end after nine bits");

  a_msb_first: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    $rose(state_q == S_BIT_RISE) |-> sda_oe_n_q == tx_q[8])
    else $error("Bit on SDA is not the top of the shift register");

  a_nack_refuse: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    (state_q == S_HOLD && accept && nack_q &&
     (cmd_code == CMD_WRITE || cmd_code == CMD_READ))
      |=> (err_q && state_q == S_HOLD))
    else $error("Data packet sent after unacknowledged address");

  a_gc_read: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    (accept && cmd_code == CMD_START && cmd_addr == ADDR_GENERAL &&
     cmd_rw == RW_READ) |=> (err_q && cmd_ready_q))
    else $error("General call with read not refused");

  a_empty_frame: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    (state_q == S_IDLE && accept && cmd_code == CMD_STOP)
      |=> (err_q && state_q == S_IDLE))
    else $error("STOP accepted without a transfer");

  a_stretch_wait: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    (state_q == S_BIT_RISE && !scl_s_q) |=> state_q == S_BIT_RISE)
    else $error("Bit continued while SCL held low");

  a_last_nack: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    (state_q == S_HOLD && accept && cmd_code == CMD_READ && !nack_q)
      |=> tx_q[0] == $past(cmd_last))
    else $error("Final read acknowledge bit wrong");

  a_open_drain: assert property (
    @(posedge clk) disable iff (!rst_n_q)
    (!scl_oe_n_q || !sda_oe_n_q) |-> (!scl_o_q && !sda_o_q))
    else $error("Line driven high");

endmodule : twbpf_host

// *** dv/twbpf_slave.sv ***
/*
  Behavioural slave on the two-wire bus, facing the master under test.
  Assumes the bench forms wired-AND lines from all enables.
*/
`timescale 1ns/100ps
module twbpf_slave #(
  parameter logic [6:0] OWN_ADDR = 7'h51
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic gc_en,
  input wire logic [7:0] rd_byte,
  input wire logic [15:0] stretch_ns,
  output logic scl_low,
  output logic sda_low,
  output logic [7:0] got_addr,
  output logic [7:0] got_data,
  output logic got_mack,
  output logic addressed
);
  logic active, in_addr, rd, hit;
  logic [7:0] sh;
  int bitcnt;

  initial begin
    {scl_low, sda_low, active, addressed, rd, hit, got_mack} = 7'h00;
    {got_addr, got_data, sh} = 24'h000000;
    in_addr = 1'b1;
    bitcnt = 0;
  end

  always @(negedge sda) begin
    if (scl) begin
      active = 1'b1;
      in_addr = 1'b1;
      addressed = 1'b0;
      bitcnt = 0;
    end
  end

  always @(posedge sda) begin
    if (scl) begin
      active = 1'b0;
      addressed = 1'b0;
      sda_low = 1'b0;
    end
  end

  always @(posedge scl) begin
    if (active) begin
      if (bitcnt < 8) sh = {sh[6:0], sda};
      else got_mack = sda;
      bitcnt++;
    end
  end

  // Changes only in the low phase; a one is a released line
  always @(negedge scl) begin
    if (active) begin
      #200;
      sda_low = 1'b0;
      if (bitcnt == 8 && in_addr) begin
        hit = (sh[7:1] == OWN_ADDR) || (gc_en && sh == 8'h00);
        got_addr = sh;
        sda_low = hit;
      end else if (bitcnt == 8) begin
        got_data = sh;
        sda_low = addressed && !rd;
      end
      if (bitcnt == 9) begin
        bitcnt = 0;
        if (in_addr) begin
          addressed = hit;
          rd = sh[0];
        end
        in_addr = 1'b0;
      end
      if (bitcnt < 8 && !in_addr && addressed && rd && !got_mack) begin
        sda_low = ~rd_byte[3'(7 - bitcnt)];
      end
      if (stretch_ns != 16'h0000) begin
        scl_low = 1'b1;
        #(stretch_ns);
        scl_low = 1'b0;
      end
    end
  end
endmodule : twbpf_slave

// *** dv/test_twbpf_host.sv ***
/*
  Self-checking bench for the two-wire bus master with one slave model.
  Assumes pull-ups on both lines, modelled by the wired-AND below.
*/
`timescale 1ns/100ps
module test_twbpf_host;
  import twbpf_pkg::*;
  localparam logic [6:0] SLV = 7'h51;
  localparam logic [7:0] RDB = 8'h3C;
  logic clk, reset_n, cmd_valid, cmd_rw, cmd_last, gc_en;
  logic [1:0] cmd_code;
  logic [6:0] cmd_addr;
  logic [7:0] cmd_data, rx_data, got_addr, got_data;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, cmd_ready, done, ack, error;
  logic bus_busy, s_scl_low, s_sda_low, got_mack, addressed;
  logic b_sda_low;
  logic scl_bus, sda_bus;
  logic [15:0] stretch_ns;
  int error_cnt, compares, cyc;
  realtime t_hi;

  assign scl_bus = (scl_oe_n | scl_o) & ~s_scl_low;
  assign sda_bus = (sda_oe_n | sda_o) & ~s_sda_low & ~b_sda_low;

  twbpf_host i_dut (.clk(clk), .reset_n(reset_n), .scl_i(scl_bus),
    .scl_o(scl_o), .scl_oe_n(scl_oe_n), .sda_i(sda_bus), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_addr(cmd_addr), .cmd_rw(cmd_rw), .cmd_data(cmd_data),
    .cmd_last(cmd_last), .cmd_ready(cmd_ready), .done(done), .ack(ack),
    .rx_data(rx_data), .error(error), .bus_busy(bus_busy));

  twbpf_slave #(.OWN_ADDR(SLV)) i_slave (.scl(scl_bus), .sda(sda_bus),
    .gc_en(gc_en), .rd_byte(RDB), .stretch_ns(stretch_ns),
    .scl_low(s_scl_low), .sda_low(s_sda_low), .got_addr(got_addr),
    .got_data(got_data), .got_mack(got_mack), .addressed(addressed));

  always #10 clk = ~clk;

  task automatic results();
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
    input string msg);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  always @(posedge clk) begin
    cyc++;
    if (cyc == 70000) begin
      error_cnt++;
      $display("BAD %0t run too long", $time);
      results();
    end
  end

  // High phase stays above 4000 ns even when stretched
  always @(posedge scl_bus) t_hi = $realtime;
  always @(negedge scl_bus) begin
    check({7'h00, ($realtime - t_hi) > 4000.0}, 8'h01, "scl high");
  end

  task automatic cmd(input logic [1:0] c, input logic [6:0] a,
    input logic r, input logic [7:0] d, input logic l, input logic e);
    int n;
    n = 0;
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_code = c;
    cmd_addr = a;
    cmd_rw = r;
    cmd_data = d;
    cmd_last = l;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    check({7'h00, error}, {7'h00, e}, "refusal pulse");
    while (!e && done !== 1'b1 && n < 20000) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (!e) check({7'h00, done}, 8'h01, "done pulse");
    check({7'h00, cmd_ready}, 8'h01, "ready");
  endtask : cmd

  task automatic t_reset();
    check({scl_oe_n, sda_oe_n, cmd_ready, bus_busy, ack, done, error,
      1'b0}, 8'hE0, "reset outputs");
    check(rx_data, 8'h00, "reset rx_data");
    check({6'h00, scl_o, sda_o}, 8'h00, "drive levels");
    $display("test reset finished");
  endtask : t_reset

  task automatic t_refuse();
    for (int k = 1; k < 4; k++) cmd(2'(k), SLV, 1'b0, 8'h00, 1'b0, 1'b1);
    cmd(CMD_START, ADDR_GENERAL, RW_READ, 8'h00, 1'b0, 1'b1);
    for (int k = 0; k < 8; k++) begin
      cmd(CMD_START, 7'h78 + 7'(k), 1'b0, 8'h00, 1'b0, 1'b1);
    end
    check({6'h00, scl_bus, sda_bus}, 8'h03, "bus untouched");
    check({7'h00, bus_busy}, 8'h00, "bus free");
    $display("test refuse finished");
  endtask : t_refuse

  task automatic t_write();
    stretch_ns = 16'd8000;
    cmd(CMD_START, SLV, 1'b0, 8'h00, 1'b0, 1'b0);
    check(got_addr, {SLV, 1'b0}, "write address");
    check({6'h00, ack, bus_busy}, 8'h03, "address ack, busy");
    cmd(CMD_WRITE, SLV, 1'b0, 8'hA5, 1'b0, 1'b0);
    check(got_data, 8'hA5, "write data");
    check({7'h00, ack}, 8'h01, "data ack");
    stretch_ns = 16'd0;
    $display("test write finished");
  endtask : t_write

  task automatic t_read();
    cmd(CMD_START, SLV, RW_READ, 8'h00, 1'b0, 1'b0);
    check(got_addr, {SLV, 1'b1}, "read address");
    check({6'h00, ack, bus_busy}, 8'h03, "repeat ack");
    cmd(CMD_READ, SLV, 1'b0, 8'h00, 1'b0, 1'b0);
    check(rx_data, RDB, "read byte");
    check({7'h00, got_mack}, 8'h00, "master ack");
    cmd(CMD_READ, SLV, 1'b0, 8'h00, 1'b1, 1'b0);
    check(rx_data, RDB, "last byte");
    check({7'h00, got_mack}, 8'h01, "master nack");
    cmd(CMD_STOP, SLV, 1'b0, 8'h00, 1'b0, 1'b0);
    check({6'h00, bus_busy, addressed}, 8'h00, "stop seen");
    $display("test read finished");
  endtask : t_read

  task automatic t_nack();
    cmd(CMD_START, 7'h2A, 1'b0, 8'h00, 1'b0, 1'b0);
    check({7'h00, ack}, 8'h00, "no slave");
    cmd(CMD_WRITE, 7'h2A, 1'b0, 8'h11, 1'b0, 1'b1);
    cmd(CMD_STOP, 7'h2A, 1'b0, 8'h00, 1'b0, 1'b0);
    check({7'h00, bus_busy}, 8'h00, "free after nack");
    $display("test nack finished");
  endtask : t_nack

  task automatic t_gcall();
    gc_en = 1'b1;
    cmd(CMD_START, ADDR_GENERAL, 1'b0, 8'h00, 1'b0, 1'b0);
    check({7'h00, ack}, 8'h01, "general call ack");
    cmd(CMD_WRITE, ADDR_GENERAL, 1'b0, 8'h81, 1'b0, 1'b0);
    check(got_data, 8'h81, "general call data");
    cmd(CMD_STOP, ADDR_GENERAL, 1'b0, 8'h00, 1'b0, 1'b0);
    gc_en = 1'b0;
    check({6'h00, scl_o, sda_o}, 8'h00, "drive levels");
    $display("test gcall finished");
  endtask : t_gcall

  // Another master holds the bus; our START must wait for its STOP
  task automatic t_busy();
    b_sda_low = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    check({7'h00, bus_busy}, 8'h01, "foreign start");
    fork
      cmd(CMD_START, SLV, 1'b0, 8'h00, 1'b0, 1'b0);
      begin
        repeat (300) @(posedge clk);
        #1;
        check({6'h00, scl_oe_n, sda_oe_n}, 8'h03, "held off");
        check({7'h00, cmd_ready}, 8'h00, "start pending");
        b_sda_low = 1'b0;
      end
    join
    check({7'h00, ack}, 8'h01, "start after free");
    cmd(CMD_STOP, SLV, 1'b0, 8'h00, 1'b0, 1'b0);
    check({7'h00, bus_busy}, 8'h00, "free again");
    $display("test busy finished");
  endtask : t_busy

  initial begin
    {clk, reset_n, cmd_valid, cmd_rw, cmd_last, gc_en} = 6'h00;
    {cmd_code, cmd_addr, cmd_data} = 17'h00000;
    b_sda_low = 1'b0;
    stretch_ns = 16'd0;
    error_cnt = 0;
    compares = 0;
    cyc = 0;
    repeat (20) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    t_reset();
    t_refuse();
    t_write();
    t_read();
    t_nack();
    t_gcall();
    t_busy();
    results();
  end
endmodule : test_twbpf_host
